// ### scs_clock_gate.v
`timescale 1ns/1ps
`include "scs_defs.vh"
// Conversion clock enable: one tick every BIT_CYCLES while enabled.
module scs_clock_gate #(
  parameter BIT_CYCLES = `SCS_BIT_CYCLES
) (
  input  wire pclk,    // System clock.
  input  wire presetn, // Asynchronous reset, active low.
  input  wire enable,  // Run the conversion clock.
  output reg  tick     // One-cycle bit period pulse.
);
  reg [7:0] count;

  // Counter restarts whenever the clock is gated off so each run is aligned.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= 8'h00;
      tick  <= 1'b0;
    end else if (!enable) begin
      count <= 8'h00;
      tick  <= 1'b0;
    end else if (count == BIT_CYCLES - 1) begin
      count <= 8'h00;
      tick  <= 1'b1;
    end else begin
      count <= count + 8'h01;
      tick  <= 1'b0;
    end
  end
endmodule

// ### scs_comparator_model.sv
`timescale 1ns/1ps
// Stands in for the divider, sampled input and comparator beside the trial DAC.
module scs_comparator_model (
  input  wire logic [11:0] trial_code, // Code on the DAC.
  input  wire logic [11:0] input_code, // Held input as a code.
  output wire logic        keep_bit    // DAC sum below input.
);
  // Equal counts as below, so an exact input converts to its own code.
  assign keep_bit = (trial_code <= input_code);
endmodule

// ### scs_defs.vh
`ifndef SCS_DEFS_VH
`define SCS_DEFS_VH
// Register byte offsets on the APB port.
`define SCS_OFF_CTRL     12'h000
`define SCS_OFF_STATUS   12'h004
`define SCS_OFF_RESULT   12'h008
`define SCS_OFF_READSEL  12'h00C
// Control register fields.
`define SCS_CTRL_START   0
`define SCS_CTRL_SHORT   1
// Status register fields.
`define SCS_STAT_BUSY    0
`define SCS_STAT_SHORT   1
`define SCS_STAT_DONE    2
// Read format register fields.
`define SCS_RSEL_FULL    0
`define SCS_RSEL_LOW     1
// Widths and reset values.
`define SCS_RES_BITS     12
`define SCS_SHORT_BITS   8
`define SCS_RESULT_RST   12'h000
`define SCS_RSEL_RST     2'h1
// Settling cycles per bit trial and start overhead.
// The comparator decision needs five cycles to come back through the DAC register
// and the three-stage synchroniser, so a bit period must be longer than that.
`define SCS_BIT_CYCLES   8
`define SCS_START_CYCLES 2
`endif

// ### scs_sar_register.v
`timescale 1ns/1ps
`include "scs_defs.vh"
// Successive approximation register, one trial per tick, MSB first.
module scs_sar_register #(
  parameter BITS = `SCS_RES_BITS
) (
  input  wire            pclk,      // System clock.
  input  wire            presetn,   // Asynchronous reset, active low.
  input  wire            clear,     // Clear to zero and arm MSB trial.
  input  wire            tick,      // Bit period strobe.
  input  wire            short_run, // Stop after eight bits.
  input  wire            comp_low,  // Comparator: DAC sum below input.
  output reg  [BITS-1:0] sar,       // Trial code to the DAC.
  output reg             eoc        // End of conversion pulse.
);
  reg [BITS-1:0] ptr;
  reg            active;
  wire           last = short_run ? ptr[BITS-`SCS_SHORT_BITS] : ptr[0];

  // Each tick settles the pointed bit; every tick but the last raises the next one.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sar    <= {BITS{1'b0}};
      ptr    <= {BITS{1'b0}};
      active <= 1'b0;
      eoc    <= 1'b0;
    end else if (clear) begin
      sar    <= {1'b1, {(BITS-1){1'b0}}};
      ptr    <= {1'b1, {(BITS-1){1'b0}}};
      active <= 1'b1;
      eoc    <= 1'b0;
    end else if (active && tick) begin
      sar <= (comp_low ? sar : (sar & ~ptr)) | (ptr >> 1);
      if (last) begin
        sar    <= comp_low ? sar : (sar & ~ptr);
        active <= 1'b0;
        eoc    <= 1'b1;
      end
      ptr <= ptr >> 1;
    end else begin
      eoc <= 1'b0;
    end
  end
endmodule

// ### scs_sequencer.v
// What this block does
// - Start enables clock, clears approximation register.
// - Running conversion cannot be aborted or restarted.
// - Result hidden while conversion runs.
// - Trial bits from MSB down to LSB.
// - Keep bit if sum below input.
// - Register holds twelve-bit binary result.
// - Last trial raises end of conversion.
// - End of conversion gates clock off.
// - Busy drops, then reads may return result.
// - Bottom of range reads all zeros.
// - Top of range reads all ones.
// - Bipolar uses offset binary, not twos-complement.
// - Busy high only during a conversion.
// - Start while busy is ignored.
// - Length select latched at conversion start.
// - Short conversion reads low bits 1000.
//
// The register addresses and register access over APB were left to the implementer.
`timescale 1ns/1ps
`include "scs_defs.vh"
module scs_sequencer #(
  parameter BITS       = `SCS_RES_BITS,
  parameter BIT_CYCLES = `SCS_BIT_CYCLES
) (
  input  wire        pclk,                   // 250 MHz APB clock.
  input  wire        presetn,                // Asynchronous reset, active low.
  input  wire        psel,                   // APB select.
  input  wire        penable,                // APB access phase.
  input  wire        pwrite,                 // APB write.
  input  wire [11:0] paddr,                  // APB byte address.
  input  wire [31:0] pwdata,                 // APB write data.
  output reg  [31:0] prdata,                 // APB read data.
  output reg         pready,                 // APB ready.
  output reg         pslverr,                // APB error on unmapped address.
  input  wire        comparator_low,         // Async comparator: DAC sum below input.
  output reg  [11:0] capacitor_trial_dac,    // Trial code to the capacitor DAC.
  output reg         conversion_busy_status, // High while converting.
  output reg         conversion_clock_on     // Internal conversion clock gate.
);
  localparam S_IDLE  = 3'b001;
  localparam S_START = 3'b010;
  localparam S_RUN   = 3'b100;

  reg  [2:0]      state;
  reg  [2:0]      next_state;
  reg  [1:0]      start_cnt;
  reg             byte_and_length_select;
  reg             done_flag;
  reg  [1:0]      read_format;
  reg  [BITS-1:0] result;
  reg  [2:0]      comp_sync;
  reg             comp_low;
  wire [BITS-1:0] sar;
  wire            eoc;
  wire            tick;
  reg             next_length;
  reg             next_clock_on;
  reg             next_busy;
  reg             next_done;
  reg  [BITS-1:0] next_result;
  reg  [31:0]     next_prdata;
  reg  [31:0]     result_word;
  wire            conv_end;
  wire            result_visible;

  wire access  = psel && penable && pready;
  wire setup   = psel && !penable;
  wire wr_ctrl = access && pwrite && (paddr == `SCS_OFF_CTRL);
  wire start_req = wr_ctrl && pwdata[`SCS_CTRL_START];
  wire clr_sar = (state == S_IDLE) && start_req;
  wire mapped  = (paddr == `SCS_OFF_CTRL) || (paddr == `SCS_OFF_STATUS) ||
                 (paddr == `SCS_OFF_RESULT) || (paddr == `SCS_OFF_READSEL);

  // Comparator crosses from the analog side; settle on second and third stage agreement.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      comp_sync <= 3'h0;
      comp_low  <= 1'b0;
    end else begin
      comp_sync <= {comp_sync[1:0], comparator_low};
      if (comp_sync[2] == comp_sync[1])
        comp_low <= comp_sync[2];
    end
  end

  scs_clock_gate #(
    .BIT_CYCLES(BIT_CYCLES)
  ) u_gate (
    .pclk    (pclk),
    .presetn (presetn),
    .enable  (conversion_clock_on),
    .tick    (tick)
  );

  scs_sar_register #(
    .BITS(BITS)
  ) u_sar (
    .pclk      (pclk),
    .presetn   (presetn),
    .clear     (clr_sar),
    .tick      (tick && (state == S_RUN)),
    .short_run (byte_and_length_select),
    .comp_low  (comp_low),
    .sar       (sar),
    .eoc       (eoc)
  );

  // Next state; only idle listens to start, so a busy conversion cannot be restarted.
  // The start state gives the trial DAC time to settle on the first trial code.
  always @* begin
    next_state = state;
    case (state)
      S_IDLE: begin
        if (start_req)
          next_state = S_START;
      end
      S_START: begin
        if (start_cnt == `SCS_START_CYCLES - 1)
          next_state = S_RUN;
      end
      S_RUN: begin
        if (eoc)
          next_state = S_IDLE;
      end
      default: next_state = S_IDLE;
    endcase
  end

  // A conversion ends only on the register's own end pulse while running.
  // Nothing from the bus can reach this term, so a run always completes.
  assign conv_end = eoc && (state == S_RUN);

  // Next values of the conversion control state.
  // Start and end can never meet in one cycle: start is heard only in idle,
  // end only in run, so no priority question arises between them.
  always @* begin
    next_length   = byte_and_length_select;
    next_clock_on = conversion_clock_on;
    next_busy     = conversion_busy_status;
    next_done     = done_flag;
    next_result   = result;
    if (clr_sar) begin
      next_length   = pwdata[`SCS_CTRL_SHORT];
      next_clock_on = 1'b1;
      next_busy     = 1'b1;
      next_done     = 1'b0;
    end else if (conv_end) begin
      next_clock_on = 1'b0;
      next_busy     = 1'b0;
      next_done     = 1'b1;
      // Straight binary code; zero input gives 000, full scale FFF.
      // A short run marks the untried bits with a one in bit three.
      if (byte_and_length_select)
        next_result = {sar[BITS-1:4], 4'h8};
      else
        next_result = sar;
    end
  end

  // Sequencer registers: clock gate, busy status, latched length and result.
  // Busy and the clock gate move in the same edge, so the gate never runs idle.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state                  <= S_IDLE;
      start_cnt              <= 2'h0;
      byte_and_length_select <= 1'b0;
      conversion_clock_on    <= 1'b0;
      conversion_busy_status <= 1'b0;
      done_flag              <= 1'b0;
      result                 <= `SCS_RESULT_RST;
      capacitor_trial_dac    <= 12'h000;
    end else begin
      state                  <= next_state;
      capacitor_trial_dac    <= sar;
      byte_and_length_select <= next_length;
      conversion_clock_on    <= next_clock_on;
      conversion_busy_status <= next_busy;
      done_flag              <= next_done;
      result                 <= next_result;
      if (state == S_START)
        start_cnt <= start_cnt + 2'h1;
      else
        start_cnt <= 2'h0;
    end
  end

  // Result is shown only once busy is low and at least one run has finished.
  // Before the first run the result register holds no conversion at all.
  assign result_visible = !conversion_busy_status && done_flag;

  // Result formats: whole word, top eight bits, or low nibble left justified.
  // The two byte formats let a narrow host fetch the result in two reads.
  always @* begin
    if (read_format[`SCS_RSEL_FULL])
      result_word = {20'h0, result};
    else if (read_format[`SCS_RSEL_LOW])
      result_word = {24'h0, result[3:0], 4'h0};
    else
      result_word = {24'h0, result[11:4]};
  end

  // Read data is decoded from the setup phase so that it stands with pready.
  // Writes and unmapped addresses read as zero.
  always @* begin
    next_prdata = 32'h00000000;
    if (!pwrite) begin
      case (paddr)
        `SCS_OFF_STATUS:
          next_prdata = {29'h0, done_flag, byte_and_length_select,
                         conversion_busy_status};
        `SCS_OFF_READSEL:
          next_prdata = {30'h0, read_format};
        `SCS_OFF_RESULT: begin
          if (result_visible)
            next_prdata = result_word;
        end
        default: next_prdata = 32'h00000000;
      endcase
    end
  end

  // Read format is the only other writable state.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      read_format <= `SCS_RSEL_RST;
    else if (access && pwrite && paddr == `SCS_OFF_READSEL)
      read_format <= pwdata[1:0];
  end

  // APB slave: no wait states, pready rises the cycle after setup.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (setup) begin
      pready  <= 1'b1;
      pslverr <= !mapped;
      prdata  <= next_prdata;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end
endmodule

// ### scs_sequencer_assertions.sv
`timescale 1ns/1ps
module scs_sequencer_assertions (
  input wire logic        pclk,                   // Clock.
  input wire logic        presetn,                // Reset, active low.
  input wire logic        psel,                   // Select.
  input wire logic        penable,                // Access phase.
  input wire logic        pwrite,                 // Write.
  input wire logic [11:0] paddr,                  // Address.
  input wire logic [31:0] pwdata,                 // Write data.
  input wire logic [31:0] prdata,                 // Read data.
  input wire logic        pready,                 // Ready.
  input wire logic        pslverr,                // Error.
  input wire logic [11:0] capacitor_trial_dac,    // Trial code.
  input wire logic        conversion_busy_status, // Busy.
  input wire logic        conversion_clock_on     // Clock gate.
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // A start write while idle launches a conversion on the next cycle.
  a_start_busy: assert property (psel && penable && pready && pwrite && paddr == 12'h000
    && pwdata[0] && !conversion_busy_status |=> conversion_busy_status) else $error("no start");
  // The conversion clock never runs outside a conversion.
  a_clock_gated: assert property (conversion_clock_on |-> conversion_busy_status)
    else $error("clock runs idle");
  a_clear_first: assert property ($rose(conversion_busy_status) |-> ##[0:3]
    (capacitor_trial_dac == 12'h000 || capacitor_trial_dac == 12'h800)) else $error("no clear");
  a_hide_busy: assert property (pready && !pwrite && paddr == 12'h008
    && $past(conversion_busy_status) |-> prdata == 32'h0) else $error("result shown");
  // Even a short run outlasts 24 cycles, so nothing cuts it off early.
  a_conv_whole: assert property ($rose(conversion_busy_status) |-> conversion_busy_status[*8]
    ##1 conversion_busy_status[*8] ##1 conversion_busy_status[*8]) else $error("cut short");
  a_conv_ends: assert property ($rose(conversion_busy_status) |-> ##[60:100]
    !conversion_busy_status) else $error("no end");
  a_upper_zero: assert property (pready && !pwrite |-> prdata[31:12] == 20'h00000)
    else $error("upper bits set");
  a_err_map: assert property (pready |-> pslverr == (paddr[11:4] != 8'h00 || paddr[1:0] != 2'h0))
    else $error("bad error flag");
endmodule
bind scs_sequencer scs_sequencer_assertions i_scs_sequencer_assertions (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .capacitor_trial_dac(capacitor_trial_dac), .conversion_busy_status(conversion_busy_status),
  .conversion_clock_on(conversion_clock_on));

// ### scs_sequencer_test.sv
`timescale 1ns/1ps
`include "scs_defs.vh"
module scs_sequencer_test;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, keep, busy, err;
  logic [11:0] paddr, dac, vin;
  logic [31:0] pwdata, prdata, rd;
  integer      fail_count, num_checks, i;
  logic [11:0] codes [6] = '{12'h000, 12'h001, 12'hFFE, 12'hFFF, 12'h800, 12'h5A3};
  always #2 pclk = ~pclk;
  scs_sequencer i_scs_sequencer (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .comparator_low(keep), .capacitor_trial_dac(dac),
    .conversion_busy_status(busy), .conversion_clock_on());
  scs_comparator_model i_scs_comparator_model (.trial_code(dac), .input_code(vin),
    .keep_bit(keep));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks = num_checks + 1;
    if (got !== exp) begin
      fail_count = fail_count + 1;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One transfer; waits for ready as long as it takes, the watchdog bounds it.
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    chk(pready, 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wait_done;
    do begin
      apb(1'b0, `SCS_OFF_STATUS, 32'h0);
    end while (rd[0] !== 1'b0);
  endtask
  task t_reset_values;
    apb(1'b0, `SCS_OFF_READSEL, 32'h0);
    chk(rd, 32'h1);
    apb(1'b0, `SCS_OFF_STATUS, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, `SCS_OFF_RESULT, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 12'h010, 32'h0);
    chk({rd[30:0], err}, 32'h1);
  endtask
  // Full run; a short start while busy must neither restart nor relatch.
  task t_full(input logic [11:0] code);
    vin <= code;
    apb(1'b1, `SCS_OFF_CTRL, 32'h1);
    apb(1'b1, `SCS_OFF_CTRL, 32'h3);
    apb(1'b0, `SCS_OFF_RESULT, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, `SCS_OFF_STATUS, 32'h0);
    chk(rd[1:0], 2'b01);
    wait_done;
    chk(rd[2:0], 3'b100);
    apb(1'b0, `SCS_OFF_RESULT, 32'h0);
    chk(rd, {20'h0, code});
  endtask
  task t_short;
    vin <= 12'hABC;
    apb(1'b1, `SCS_OFF_CTRL, 32'h3);
    apb(1'b1, `SCS_OFF_CTRL, 32'h1);
    wait_done;
    chk(rd[2:0], 3'b110);
    apb(1'b0, `SCS_OFF_RESULT, 32'h0);
    chk(rd, 32'hAB8);
    apb(1'b1, `SCS_OFF_READSEL, 32'h0);
    apb(1'b0, `SCS_OFF_RESULT, 32'h0);
    chk(rd, 32'hAB);
    apb(1'b1, `SCS_OFF_READSEL, 32'h2);
    apb(1'b0, `SCS_OFF_RESULT, 32'h0);
    chk(rd, 32'h80);
    apb(1'b1, `SCS_OFF_READSEL, 32'h1);
  endtask
  task give_verdict;
    if (fail_count == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Watchdog: the whole sequence needs a few thousand cycles at most.
  initial begin
    #100000;
    fail_count = fail_count + 1;
    give_verdict;
  end
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata, vin} = '0;
    fail_count = 0;
    num_checks = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset_values;
    for (i = 0; i < 6; i = i + 1) t_full(codes[i]);
    t_short;
    t_full(12'h3C5);
    give_verdict;
  end
endmodule
